// *** pkg/flash_stage_pkg.sv ***
// Constants, register map and field layout of the flash sector select and data stage.
// Assumes a 100 MHz system clock and an APB master with 32-bit data and 8-bit byte addresses.
package flash_stage_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int BANK0_SECTORS = 10;
	localparam int BANK1_SECTORS = 2;
	localparam int SECTORS = BANK0_SECTORS + BANK1_SECTORS;
	localparam int BANKS = 2;
	localparam int IRQ_W = 3;

	// Printed offsets are register indices; the byte address is four times the index.
	localparam logic [23:0] REG_BASE = 24'h0E0000;
	localparam logic [23:0] IDX_SEL_LO = 24'h0E0004;
	localparam logic [23:0] IDX_SEL_HI = 24'h0E0006;
	localparam logic [23:0] IDX_D0_LO = 24'h0E0008;
	localparam logic [23:0] IDX_D0_HI = 24'h0E000A;
	localparam logic [23:0] IDX_D1_LO = 24'h0E000C;
	localparam logic [23:0] IDX_D1_HI = 24'h0E000E;
	localparam logic [23:0] IDX_IRQ_STAT = 24'h0E0010;
	localparam logic [23:0] IDX_IRQ_MASK = 24'h0E0011;

	localparam logic [ADDR_W-1:0] ADDR_SEL_LO = ADDR_W'((IDX_SEL_LO - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_SEL_HI = ADDR_W'((IDX_SEL_HI - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_D0_LO = ADDR_W'((IDX_D0_LO - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_D0_HI = ADDR_W'((IDX_D0_HI - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_D1_LO = ADDR_W'((IDX_D1_LO - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_D1_HI = ADDR_W'((IDX_D1_HI - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = ADDR_W'((IDX_IRQ_STAT - REG_BASE) << 2);
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = ADDR_W'((IDX_IRQ_MASK - REG_BASE) << 2);

	// High selection register layout.
	localparam int HI_B1F_LSB = 0;
	localparam int HI_B0S_BIT = 8;
	localparam int HI_B1S_BIT = 9;

	localparam logic [HALF_W-1:0] SEL_RESET = 16'h0000;
	localparam logic [HALF_W-1:0] DATA_RESET = 16'hFFFF;
	localparam logic [DATA_W-1:0] WORD_ERASED = 32'hFFFFFFFF;

	// Interrupt status bits.
	localparam int IRQ_ERASE_DONE = 0;
	localparam int IRQ_OP_FAIL = 1;
	localparam int IRQ_SETUP_ERR = 2;

	typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM} op_e;

endpackage

// *** src/stage_half.sv ***
// One 16-bit software register with byte-lane writes.
// Assumes the write strobe is a one-cycle pulse from the bus slave.
module stage_half
	import flash_stage_pkg::*;
#(
	parameter logic [HALF_W-1:0] RESET_VAL = DATA_RESET
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_we,
	input wire logic [1:0] i_be,
	input wire logic [HALF_W-1:0] i_wdata,
	output logic [HALF_W-1:0] o_q
);

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_q <= RESET_VAL;
		else if (i_we)
		begin
			if (i_be[0])
				o_q[7:0] <= i_wdata[7:0];
			if (i_be[1])
				o_q[15:8] <= i_wdata[15:8];
		end
	end

endmodule

// *** src/irq_status.sv ***
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes events and writes arrive on the same clock.
module irq_status
	import flash_stage_pkg::*;
#(
	parameter int W = IRQ_W
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_set,
	input wire logic i_clr_we,
	input wire logic i_mask_we,
	input wire logic [W-1:0] i_wdata,
	output logic [W-1:0] o_status,
	output logic [W-1:0] o_mask,
	output logic o_irq
);

	logic [W-1:0] status_d;

	// A set in the clearing cycle survives.
	always_comb
	begin
		status_d = o_status;
		if (i_clr_we)
			status_d = status_d & ~i_wdata;
		status_d = status_d | i_set;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_status <= '0;
		else
			o_status <= status_d;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_mask <= '0;
		else if (i_mask_we)
			o_mask <= i_wdata;
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_irq <= 1'b0;
		else
			o_irq <= |(status_d & o_mask);
	end

endmodule

// *** src/flash_sector_select_and_data_stage.sv ***
// Sector selection and status registers, data staging registers and APB slave of the
// flash write controller.
// Assumes the erase/program engine and the control and error registers sit outside and
// run on the same clock, so their signals are used without synchronisers.
//
// The APB slave port was decided locally.
module flash_sector_select_and_data_stage
	import flash_stage_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [ADDR_W-1:0] I_PADDR,
	input wire logic [DATA_W-1:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [DATA_W-1:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_WRITE_START,
	input wire logic I_ERASE_SELECT,
	input wire logic I_DOUBLE_WORD_PROGRAM_SELECT,
	input wire logic I_SUSPEND_REQUEST,
	input wire logic I_WRITE_ERROR,
	input wire logic I_ERASE_BUSY,
	input wire logic I_OP_DONE,
	input wire logic I_OP_ERROR,
	input wire logic [SECTORS-1:0] I_SECTOR_STATE,
	input wire logic [BANKS-1:0] I_BANK_STATE,
	output logic [SECTORS-1:0] O_ERASE_SECTORS,
	output logic O_ERASE_BANK,
	output logic O_ERASE_GO,
	output logic O_PROG_GO,
	output logic [DATA_W-1:0] O_PROG_EVEN,
	output logic [DATA_W-1:0] O_PROG_ODD,
	output logic O_SETUP_ERROR,
	output logic [SECTORS-1:0] O_SECTOR_FAIL,
	output logic [SECTORS-1:0] O_SECTOR_SUSPEND_REQUEST,
	output logic [BANKS-1:0] O_BANK_FAIL,
	output logic [BANKS-1:0] O_BANK_SUSPEND_REQUEST,
	output logic O_IRQ
);

	logic setup_phase;
	logic access_done;
	logic wr_en;
	logic mapped;
	logic [DATA_W-1:0] rd_data;

	logic [SECTORS-1:0] sector_q;
	logic [BANKS-1:0] bank_state_q;
	op_e op_q;

	logic [HALF_W-1:0] d0_lo;
	logic [HALF_W-1:0] d0_hi;
	logic [HALF_W-1:0] d1_lo;
	logic [HALF_W-1:0] d1_hi;

	logic [BANK0_SECTORS-1:0] bank0_sel;
	logic [BANK1_SECTORS-1:0] bank1_sel;
	logic bank0_any;
	logic bank1_any;
	logic erase_setup_bad;
	logic start_refused;
	logic erase_start;
	logic prog_start;
	logic op_end_ok;
	logic op_end_fail;

	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;

	logic [HALF_W-1:0] sel_lo_view;
	logic [HALF_W-1:0] sel_hi_view;

	// Bus phases: the answer is prepared during setup so every bus output is a flop.
	assign setup_phase = I_PSEL && !I_PENABLE;
	assign access_done = I_PSEL && I_PENABLE && O_PREADY;
	assign wr_en = access_done && I_PWRITE && !O_PSLVERR;

	always_comb
	begin
		case (I_PADDR)
			ADDR_SEL_LO,
			ADDR_SEL_HI,
			ADDR_D0_LO,
			ADDR_D0_HI,
			ADDR_D1_LO,
			ADDR_D1_HI,
			ADDR_IRQ_STAT,
			ADDR_IRQ_MASK:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end

	// Reserved positions of the sector views are constant zero.
	always_comb
	begin
		sel_lo_view = '0;
		sel_lo_view[BANK0_SECTORS-1:0] = sector_q[BANK0_SECTORS-1:0];
		sel_hi_view = '0;
		sel_hi_view[HI_B1F_LSB +: BANK1_SECTORS] = sector_q[SECTORS-1:BANK0_SECTORS];
		sel_hi_view[HI_B0S_BIT] = bank_state_q[0];
		sel_hi_view[HI_B1S_BIT] = bank_state_q[1];
	end

	always_comb
	begin
		rd_data = '0;
		case (I_PADDR)
			ADDR_SEL_LO:
				rd_data[HALF_W-1:0] = sel_lo_view;
			ADDR_SEL_HI:
				rd_data[HALF_W-1:0] = sel_hi_view;
			ADDR_D0_LO:
				rd_data[HALF_W-1:0] = d0_lo;
			ADDR_D0_HI:
				rd_data[HALF_W-1:0] = d0_hi;
			ADDR_D1_LO:
				rd_data[HALF_W-1:0] = d1_lo;
			ADDR_D1_HI:
				rd_data[HALF_W-1:0] = d1_hi;
			ADDR_IRQ_STAT:
				rd_data[IRQ_W-1:0] = irq_stat;
			ADDR_IRQ_MASK:
				rd_data[IRQ_W-1:0] = irq_mask;
			default:
				rd_data = '0;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			O_PREADY <= 1'b0;
		else
			O_PREADY <= setup_phase;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			O_PSLVERR <= 1'b0;
		else if (setup_phase)
			O_PSLVERR <= !mapped;
		else
			O_PSLVERR <= 1'b0;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			O_PRDATA <= '0;
		else if (setup_phase && !I_PWRITE)
			O_PRDATA <= rd_data;
	end

	// Staging halves: word = high half 31:16 over low half 15:0.
	stage_half #(.RESET_VAL(DATA_RESET)) u_d0_lo (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_we(wr_en && I_PADDR == ADDR_D0_LO),
		.i_be(I_PSTRB[1:0]),
		.i_wdata(I_PWDATA[HALF_W-1:0]),
		.o_q(d0_lo)
	);

	stage_half #(.RESET_VAL(DATA_RESET)) u_d0_hi (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_we(wr_en && I_PADDR == ADDR_D0_HI),
		.i_be(I_PSTRB[1:0]),
		.i_wdata(I_PWDATA[HALF_W-1:0]),
		.o_q(d0_hi)
	);

	stage_half #(.RESET_VAL(DATA_RESET)) u_d1_lo (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_we(wr_en && I_PADDR == ADDR_D1_LO),
		.i_be(I_PSTRB[1:0]),
		.i_wdata(I_PWDATA[HALF_W-1:0]),
		.o_q(d1_lo)
	);

	stage_half #(.RESET_VAL(DATA_RESET)) u_d1_hi (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_we(wr_en && I_PADDR == ADDR_D1_HI),
		.i_be(I_PSTRB[1:0]),
		.i_wdata(I_PWDATA[HALF_W-1:0]),
		.o_q(d1_hi)
	);

	// Start qualification.
	assign bank0_sel = sector_q[BANK0_SECTORS-1:0];
	assign bank1_sel = sector_q[SECTORS-1:BANK0_SECTORS];
	assign bank0_any = |bank0_sel;
	assign bank1_any = |bank1_sel;
	// An erase needs at least one sector and all of them in one bank.
	assign erase_setup_bad = !(bank0_any ^ bank1_any);
	// A start is refused while the write error stands or a new start meets a suspend.
	assign start_refused = I_WRITE_ERROR || (op_q == OP_IDLE && I_SUSPEND_REQUEST);
	assign erase_start = I_WRITE_START && I_ERASE_SELECT && op_q == OP_IDLE
		&& !start_refused && !erase_setup_bad;
	assign prog_start = I_WRITE_START && !I_ERASE_SELECT && op_q == OP_IDLE && !start_refused;
	assign op_end_ok = I_OP_DONE && !I_OP_ERROR && op_q != OP_IDLE;
	assign op_end_fail = I_OP_DONE && I_OP_ERROR && op_q != OP_IDLE;

	// Operation tracking; a suspended operation stays in its state until it ends.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			op_q <= OP_IDLE;
		else
		begin
			case (op_q)
				OP_IDLE:
					if (erase_start)
						op_q <= OP_ERASE;
					else if (prog_start)
						op_q <= OP_PROGRAM;
				OP_ERASE,
				OP_PROGRAM:
					if (I_OP_DONE)
						op_q <= OP_IDLE;
				default:
					op_q <= OP_IDLE;
			endcase
		end
	end

	// Sector bits: software selection when idle, engine state during erase.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			sector_q <= '0;
		else if (op_q == OP_ERASE && I_ERASE_BUSY)
			sector_q <= I_SECTOR_STATE;
		else if (op_end_ok)
			sector_q <= '0;
		else if (wr_en && op_q == OP_IDLE && I_PADDR == ADDR_SEL_LO)
		begin
			// Only the sector field takes the write.
			if (I_PSTRB[0])
				sector_q[7:0] <= I_PWDATA[7:0];
			if (I_PSTRB[1])
				sector_q[BANK0_SECTORS-1:8] <= I_PWDATA[BANK0_SECTORS-1:8];
		end
		else if (wr_en && op_q == OP_IDLE && I_PADDR == ADDR_SEL_HI && I_PSTRB[0])
			sector_q[SECTORS-1:BANK0_SECTORS] <= I_PWDATA[HI_B1F_LSB +: BANK1_SECTORS];
	end

	// Bank state bits are read-only; a failed erase leaves them for inspection.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			bank_state_q <= '0;
		else if (op_q == OP_ERASE && I_ERASE_BUSY)
			bank_state_q <= I_BANK_STATE;
		else if (op_end_ok && op_q == OP_ERASE)
			bank_state_q <= '0;
	end

	// Engine commands, taken from the selection at the start.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_ERASE_SECTORS <= '0;
			O_ERASE_BANK <= 1'b0;
			O_ERASE_GO <= 1'b0;
		end
		else
		begin
			O_ERASE_GO <= erase_start;
			if (erase_start)
			begin
				O_ERASE_SECTORS <= sector_q;
				O_ERASE_BANK <= bank1_any;
			end
		end
	end

	// Program data is sampled only at a program start.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_PROG_EVEN <= WORD_ERASED;
			O_PROG_ODD <= WORD_ERASED;
			O_PROG_GO <= 1'b0;
		end
		else
		begin
			O_PROG_GO <= prog_start;
			if (prog_start)
			begin
				O_PROG_EVEN <= {d0_hi, d0_lo};
				// All ones programs nothing, so a single word leaves the odd slot harmless.
				O_PROG_ODD <= I_DOUBLE_WORD_PROGRAM_SELECT ? {d1_hi, d1_lo} : WORD_ERASED;
			end
		end
	end

	// A refused or badly set up start is reported to the error register.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			O_SETUP_ERROR <= 1'b0;
		else
			O_SETUP_ERROR <= I_WRITE_START && op_q == OP_IDLE
				&& (start_refused || (I_ERASE_SELECT && erase_setup_bad));
	end

	// Decoded meaning of the status bits.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_SECTOR_FAIL <= '0;
			O_SECTOR_SUSPEND_REQUEST <= '0;
			O_BANK_FAIL <= '0;
			O_BANK_SUSPEND_REQUEST <= '0;
		end
		else
		begin
			O_SECTOR_FAIL <= I_WRITE_ERROR ? sector_q : '0;
			O_BANK_FAIL <= I_WRITE_ERROR ? bank_state_q : '0;
			// Suspend is reported while software holds the request and no write error stands.
			O_SECTOR_SUSPEND_REQUEST <= (!I_WRITE_ERROR && I_SUSPEND_REQUEST) ? sector_q : '0;
			O_BANK_SUSPEND_REQUEST <= (!I_WRITE_ERROR && I_SUSPEND_REQUEST) ? bank_state_q : '0;
		end
	end

	always_comb
	begin
		irq_set = '0;
		irq_set[IRQ_ERASE_DONE] = op_end_ok && op_q == OP_ERASE;
		irq_set[IRQ_OP_FAIL] = op_end_fail;
		irq_set[IRQ_SETUP_ERR] = I_WRITE_START && op_q == OP_IDLE
			&& (start_refused || (I_ERASE_SELECT && erase_setup_bad));
	end

	irq_status #(.W(IRQ_W)) u_irq (
		.i_clk(I_REF_CLK),
		.i_rstn(I_RSTN),
		.i_set(irq_set),
		.i_clr_we(wr_en && I_PADDR == ADDR_IRQ_STAT && I_PSTRB[0]),
		.i_mask_we(wr_en && I_PADDR == ADDR_IRQ_MASK && I_PSTRB[0]),
		.i_wdata(I_PWDATA[IRQ_W-1:0]),
		.o_status(irq_stat),
		.o_mask(irq_mask),
		.o_irq(O_IRQ)
	);

endmodule

// *** test/fss_props.sv ***
// Checker of the sector select and data stage, watching only the top module ports.
// Assumes the single clock and the one-cycle start and status timing of the block.
module fss_props
	import flash_stage_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_WRITE_START,
	input wire logic I_WRITE_ERROR,
	input wire logic I_SUSPEND_REQUEST,
	input wire logic I_DOUBLE_WORD_PROGRAM_SELECT,
	input wire logic O_PREADY,
	input wire logic O_PSLVERR,
	input wire logic O_ERASE_GO,
	input wire logic O_PROG_GO,
	input wire logic O_SETUP_ERROR,
	input wire logic O_ERASE_BANK,
	input wire logic [SECTORS-1:0] O_ERASE_SECTORS,
	input wire logic [DATA_W-1:0] O_PROG_ODD,
	input wire logic [SECTORS-1:0] O_SECTOR_FAIL,
	input wire logic [SECTORS-1:0] O_SECTOR_SUSPEND_REQUEST,
	input wire logic [BANKS-1:0] O_BANK_FAIL,
	input wire logic [BANKS-1:0] O_BANK_SUSPEND_REQUEST
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RSTN);
	property p_ready;
		I_PSEL && !I_PENABLE |=> O_PREADY;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready after setup");
	property p_slverr;
		O_PSLVERR |-> O_PREADY;
	endproperty
	a_slverr: assert property (p_slverr) else $error("error without ready");
	property p_err_nogo;
		I_WRITE_START && I_WRITE_ERROR |=> !O_ERASE_GO && !O_PROG_GO;
	endproperty
	a_err_nogo: assert property (p_err_nogo) else $error("start taken with error");
	property p_one_bank;
		O_ERASE_GO |-> (O_ERASE_SECTORS[11:10] == 2'h0) != (O_ERASE_SECTORS[9:0] == 10'h000);
	endproperty
	a_one_bank: assert property (p_one_bank) else $error("erase not in one bank");
	property p_bank_sel;
		O_ERASE_GO |-> O_ERASE_BANK == (O_ERASE_SECTORS[9:0] == 10'h000);
	endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("erase bank wrong");
	property p_odd;
		O_PROG_GO && !$past(I_DOUBLE_WORD_PROGRAM_SELECT) |-> O_PROG_ODD == 32'hFFFFFFFF;
	endproperty
	a_odd: assert property (p_odd) else $error("odd word not erased value");
	property p_fail;
		!$past(I_WRITE_ERROR) |-> O_SECTOR_FAIL == 12'h000 && O_BANK_FAIL == 2'h0;
	endproperty
	a_fail: assert property (p_fail) else $error("failure shown without error");
	property p_suspend_request;
		$past(I_WRITE_ERROR) || !$past(I_SUSPEND_REQUEST) |->
			O_SECTOR_SUSPEND_REQUEST == 12'h000 && O_BANK_SUSPEND_REQUEST == 2'h0;
	endproperty
	a_suspend_request: assert property (p_suspend_request) else $error("suspend shown wrongly");
	c_erase: cover property (O_ERASE_GO);
	c_prog: cover property (O_PROG_GO);
	c_setup: cover property (O_SETUP_ERROR);
endmodule

bind flash_sector_select_and_data_stage fss_props u_props (.I_REF_CLK(I_REF_CLK),
	.I_RSTN(I_RSTN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_WRITE_START(I_WRITE_START),
	.I_WRITE_ERROR(I_WRITE_ERROR), .I_SUSPEND_REQUEST(I_SUSPEND_REQUEST),
	.I_DOUBLE_WORD_PROGRAM_SELECT(I_DOUBLE_WORD_PROGRAM_SELECT), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .O_ERASE_GO(O_ERASE_GO), .O_PROG_GO(O_PROG_GO),
	.O_SETUP_ERROR(O_SETUP_ERROR), .O_ERASE_BANK(O_ERASE_BANK),
	.O_ERASE_SECTORS(O_ERASE_SECTORS), .O_PROG_ODD(O_PROG_ODD),
	.O_SECTOR_FAIL(O_SECTOR_FAIL), .O_SECTOR_SUSPEND_REQUEST(O_SECTOR_SUSPEND_REQUEST),
	.O_BANK_FAIL(O_BANK_FAIL), .O_BANK_SUSPEND_REQUEST(O_BANK_SUSPEND_REQUEST));

// *** test/tb_top.sv ***
// Self-checking bench of the sector select and data stage.
// Assumes a single-clock APB slave that answers in its own time; the bench plays CPU and engine.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_stage_pkg::*;
	logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwd = 32'h0, prd, peven, podd;
	logic [3:0] pstrb = 4'h3;
	logic prdy, perr, ebank, ego, pgo, serr, irq;
	logic ws = 0, es = 0, dw = 0, sus = 0, werr = 0, busy = 0, done = 0, oerr = 0;
	logic [11:0] sst = 12'h000, esec, sfail, ssusp;
	logic [1:0] bst = 2'h0, bfail, bsusp;
	logic [32:0] q[$];
	int bad_count = 0, checked = 0;
	flash_sector_select_and_data_stage dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwd), .I_PSTRB(pstrb),
		.O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .I_WRITE_START(ws),
		.I_ERASE_SELECT(es), .I_DOUBLE_WORD_PROGRAM_SELECT(dw), .I_SUSPEND_REQUEST(sus),
		.I_WRITE_ERROR(werr), .I_ERASE_BUSY(busy), .I_OP_DONE(done), .I_OP_ERROR(oerr),
		.I_SECTOR_STATE(sst), .I_BANK_STATE(bst), .O_ERASE_SECTORS(esec),
		.O_ERASE_BANK(ebank), .O_ERASE_GO(ego), .O_PROG_GO(pgo), .O_PROG_EVEN(peven),
		.O_PROG_ODD(podd), .O_SETUP_ERROR(serr), .O_SECTOR_FAIL(sfail),
		.O_SECTOR_SUSPEND_REQUEST(ssusp), .O_BANK_FAIL(bfail), .O_BANK_SUSPEND_REQUEST(bsusp), .O_IRQ(irq));
	always #5 clk = ~clk;
	task automatic stop_test();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Read data is taken at the edge that completes the access, as a CPU would take it.
	always @(posedge clk)
		if (psel && pen && prdy === 1'b1 && !pwr)
			chk({perr, prd}, q.pop_front());
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (n > 20)
			begin
				bad_count++;
				stop_test();
			end
		end
		while (prdy !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic start(input logic e, input logic d);
		@(posedge clk);
		ws <= 1'b1;
		es <= e;
		dw <= d;
		@(posedge clk);
		ws <= 1'b0;
		@(negedge clk);
	endtask
	task automatic fin();
		@(posedge clk);
		busy <= 1'b0;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
	endtask
	initial
	begin
		logic [31:0] s, d0, d1;
		void'($urandom(32'h67b4));
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rd(ADDR_SEL_LO, 33'h0);
		rd(ADDR_SEL_HI, 33'h0);
		rd(ADDR_D0_LO, 33'hFFFF);
		rd(ADDR_D0_HI, 33'hFFFF);
		rd(ADDR_D1_LO, 33'hFFFF);
		rd(ADDR_D1_HI, 33'hFFFF);
		rd(8'h08, 33'h100000000);
		wr(ADDR_SEL_LO, 32'hFFFF);
		rd(ADDR_SEL_LO, 33'h3FF);
		wr(ADDR_SEL_HI, 32'hFFFF);
		rd(ADDR_SEL_HI, 33'h3);
		wr(ADDR_SEL_HI, 32'h0);
		wr(ADDR_SEL_LO, 32'h205);
		start(1'b1, 1'b0);
		chk(33'(ego), 33'h1);
		chk(33'({ebank, esec}), 33'h205);
		s = $urandom;
		@(posedge clk);
		busy <= 1'b1;
		sst <= s[11:0];
		bst <= s[13:12];
		repeat (2) @(posedge clk);
		rd(ADDR_SEL_LO, {23'h0, s[9:0]});
		rd(ADDR_SEL_HI, {23'h0, s[13:12], 6'h0, s[11:10]});
		@(posedge clk);
		werr <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk(33'({bfail, sfail}), 33'(s[13:0]));
		@(posedge clk);
		werr <= 1'b0;
		sus <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk(33'({bsusp, ssusp, sfail}), 33'({s[13:0], 12'h000}));
		@(posedge clk);
		sus <= 1'b0;
		fin();
		rd(ADDR_SEL_LO, 33'h0);
		rd(ADDR_SEL_HI, 33'h0);
		rd(ADDR_IRQ_STAT, 33'h1);
		wr(ADDR_IRQ_MASK, 32'h7);
		// The new mask reaches the interrupt output one edge after the write lands.
		@(posedge clk);
		@(negedge clk);
		chk(33'(irq), 33'h1);
		wr(ADDR_IRQ_STAT, 32'h1);
		@(negedge clk);
		chk(33'(irq), 33'h0);
		wr(ADDR_SEL_LO, 32'h1);
		wr(ADDR_SEL_HI, 32'h1);
		start(1'b1, 1'b0);
		chk(33'({serr, ego}), 33'h2);
		wr(ADDR_IRQ_STAT, 32'h4);
		@(posedge clk);
		werr <= 1'b1;
		start(1'b0, 1'b0);
		chk(33'({serr, pgo}), 33'h2);
		@(posedge clk);
		werr <= 1'b0;
		d0 = $urandom;
		d1 = $urandom;
		wr(ADDR_D0_LO, {16'h0, d0[15:0]});
		wr(ADDR_D0_HI, {16'h0, d0[31:16]});
		wr(ADDR_D1_LO, {16'h0, d1[15:0]});
		wr(ADDR_D1_HI, {16'h0, d1[31:16]});
		start(1'b0, 1'b1);
		chk(33'(pgo), 33'h1);
		chk(33'(peven), 33'(d0));
		chk(33'(podd), 33'(d1));
		fin();
		rd(ADDR_SEL_LO, 33'h0);
		start(1'b0, 1'b0);
		chk(33'(podd), 33'hFFFFFFFF);
		chk(33'(peven), 33'(d0));
		fin();
		wr(ADDR_SEL_HI, 32'h2);
		start(1'b1, 1'b0);
		chk(33'({ego, ebank, esec}), 33'h3800);
		// A failed erase must leave the sector bits for inspection.
		@(posedge clk);
		oerr <= 1'b1;
		fin();
		oerr <= 1'b0;
		rd(ADDR_SEL_HI, 33'h2);
		rd(ADDR_IRQ_STAT, 33'h6);
		chk(33'(irq), 33'h1);
		pstrb <= 4'h1;
		wr(ADDR_D1_LO, 32'hA55A);
		pstrb <= 4'h3;
		rd(ADDR_D1_LO, {17'h0, d1[15:8], 8'h5A});
		repeat (2) @(posedge clk);
		stop_test();
	end
endmodule
